// [include/low_power_consts.svh]
`ifndef LOW_POWER_CONSTS_SVH
`define LOW_POWER_CONSTS_SVH
// oscillator stabilization delay on leaving stop, in internal processor clocks
`define OSC_STAB_CYCLES   4064
`define OSC_STAB_W        12
// bit positions of the timer control bits touched on stop entry
`define TIMER_CTRL_CAPT_IE_BIT 7
`define TIMER_CTRL_CMP_IE_BIT  6
`define TIMER_CTRL_OVF_IE_BIT  5
`define PORT_W            8
`endif

// [include/low_power_pkg.sv]
package low_power_pkg;
    typedef enum logic [2:0] {
        ST_RUN  = 3'b000,
        ST_STOP = 3'b001,
        ST_STAB = 3'b010,
        ST_WAIT = 3'b011
    } mode_e;

    // side effects raised toward the cpu and timer
    typedef struct packed {
        logic clr_i_bit;
        logic set_external_irq_enable;
        logic clr_timer_ie;
        logic clr_timer_pend;
        logic clr_prescaler;
    } side_fx_s;

    // wake sources presented to the block
    typedef struct packed {
        logic irq_pin;
        logic timer_irq;
        logic bus_pin;
    } wake_in_s;
endpackage : low_power_pkg

// [core/port_wake_detect.sv]
`include "low_power_consts.svh"
// falling edge of the and-combined input pins of both ports
module port_wake_detect #(
    parameter int W = `PORT_W
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    // pins and direction
    input  wire logic [W-1:0] port_a_pins,
    input  wire logic [W-1:0] port_c_pins,
    input  wire logic [W-1:0] port_a_direction_reg,
    input  wire logic [W-1:0] port_c_direction_reg,
    // result
    output logic              port_fall
);
    // outputs are masked high so they cannot pull the and low
    wire logic [W-1:0] a_masked = port_a_pins | port_a_direction_reg;
    wire logic [W-1:0] c_masked = port_c_pins | port_c_direction_reg;
    // a held-low input keeps the and low, so later edges are lost
    wire logic         all_high = (&a_masked) & (&c_masked);
    logic              all_high_q;
    wire logic         fall_d   = all_high_q & ~all_high;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            all_high_q <= 1'b1;
            port_fall  <= 1'b0;
        end else begin
            all_high_q <= all_high;
            port_fall  <= fall_d;
        end
    end

    AST_OUTPUT_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (&port_a_direction_reg) && (&port_c_direction_reg) && $stable(port_a_direction_reg)
        && $stable(port_c_direction_reg) |=> !port_fall)
        else $error("output pin raised a port wake");
    AST_FALL_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_b)
        port_fall |-> $past(all_high_q) && !$past(all_high))
        else $error("port wake without falling edge");
endmodule : port_wake_detect

// [core/low_power_mode_control.sv]
// How it works
// - stop executes stop, or resets if disabled
// - stop turns oscillator off, halting watchdog
// - stop entry clears timer pending and enables
// - stop entry clears the timer prescaler
// - stop entry clears I, sets external irq enable
// - stop leaves other state untouched
// - stop wakes on irq, reset, port, bus
// - stop exit waits 4064 clocks for oscillator
// - wait halts cpu clock, timer clocks run
// - wait still allows timer irq, watchdog reset
// - wait instruction clears the I bit
// - wait leaves other state untouched
// - wait wakes on timer, irq, reset, port, bus
// - output-direction port pins never wake
// - port wake on falling edge of and
`include "low_power_consts.svh"
module low_power_mode_control #(
    parameter int STAB_CYCLES = `OSC_STAB_CYCLES,
    parameter int W           = `PORT_W
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_b,
    // cpu instruction strobes and option
    input  wire logic                    stop_exec,
    input  wire logic                    wait_exec,
    input  wire logic                    stop_option_en,
    // wake sources
    input  wire low_power_pkg::wake_in_s wake_in,
    input  wire logic                    int_reset,
    input  wire logic [W-1:0]            port_a_pins,
    input  wire logic [W-1:0]            port_c_pins,
    input  wire logic [W-1:0]            port_a_direction_reg,
    input  wire logic [W-1:0]            port_c_direction_reg,
    // clock gating
    output logic                         osc_en,
    output logic                         cpu_clk_en,
    output logic                         timer_clk_en,
    output logic                         watchdog_clk_en,
    // side effects and reset request
    output low_power_pkg::side_fx_s      side_fx,
    output logic                         chip_reset_req,
    output logic [2:0]                   mode
);
    low_power_pkg::mode_e state_q, state_d;
    logic [`OSC_STAB_W-1:0] cnt_q, cnt_d;
    logic                   port_fall;

    // state compare shared by the assertions and the cover points
    function automatic logic in_state(input low_power_pkg::mode_e s, input low_power_pkg::mode_e want);
        return s == want;
    endfunction : in_state

    port_wake_detect #(.W(W)) u_port (
        .clk_sys              (clk_sys),
        .rst_b                (rst_b),
        .port_a_pins          (port_a_pins),
        .port_c_pins          (port_c_pins),
        .port_a_direction_reg (port_a_direction_reg),
        .port_c_direction_reg (port_c_direction_reg),
        .port_fall            (port_fall)
    );

    // rising edge of the serial network bus pin
    logic bus_q;
    wire logic bus_rise   = wake_in.bus_pin & ~bus_q;
    // internal reset is itself a wake source; external reset acts via rst_b
    wire logic stop_wake  = wake_in.irq_pin | int_reset | port_fall | bus_rise;
    wire logic wait_wake  = stop_wake | wake_in.timer_irq;
    wire logic go_stop    = stop_exec & stop_option_en;
    wire logic go_reset   = stop_exec & ~stop_option_en;
    wire logic go_wait    = wait_exec & ~stop_exec;
    wire logic [`OSC_STAB_W-1:0] stab_last = (`OSC_STAB_W)'(STAB_CYCLES - 1);
    wire logic in_run     = in_state(state_q, low_power_pkg::ST_RUN);
    wire logic in_stop    = in_state(state_q, low_power_pkg::ST_STOP);
    wire logic in_stab    = in_state(state_q, low_power_pkg::ST_STAB);
    wire logic in_wait    = in_state(state_q, low_power_pkg::ST_WAIT);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            low_power_pkg::ST_RUN: begin
                if (go_stop) begin
                    state_d = low_power_pkg::ST_STOP;
                end else if (go_wait) begin
                    state_d = low_power_pkg::ST_WAIT;
                end
            end
            low_power_pkg::ST_STOP: begin
                if (stop_wake) begin
                    state_d = low_power_pkg::ST_STAB;
                    cnt_d   = '0;
                end
            end
            low_power_pkg::ST_STAB: begin
                // cpu clock held off until the oscillator has settled
                if (cnt_q == stab_last) begin
                    state_d = low_power_pkg::ST_RUN;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            low_power_pkg::ST_WAIT: begin
                // oscillator never stopped, so no settle time is needed
                if (wait_wake) begin
                    state_d = low_power_pkg::ST_RUN;
                end
            end
            default: state_d = low_power_pkg::ST_RUN;
        endcase
    end

    // side effects pulse once on entry; nothing else is touched
    wire low_power_pkg::side_fx_s fx_d = '{
        clr_i_bit:      (state_q == low_power_pkg::ST_RUN) & (go_stop | go_wait),
        set_external_irq_enable:       (state_q == low_power_pkg::ST_RUN) & go_stop,
        clr_timer_ie:   (state_q == low_power_pkg::ST_RUN) & go_stop,
        clr_timer_pend: (state_q == low_power_pkg::ST_RUN) & go_stop,
        clr_prescaler:  (state_q == low_power_pkg::ST_RUN) & go_stop
    };
    wire logic osc_on   = (state_d != low_power_pkg::ST_STOP);
    wire logic cpu_on   = (state_d == low_power_pkg::ST_RUN);
    wire logic timer_on = (state_d == low_power_pkg::ST_RUN) || (state_d == low_power_pkg::ST_WAIT);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= low_power_pkg::ST_RUN;
            cnt_q   <= '0;
            bus_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            bus_q   <= wake_in.bus_pin;
        end
    end

    // gates are registered so a decode hazard never glitches a clock
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            osc_en <= 1'b1;
        end else begin
            osc_en <= osc_on;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cpu_clk_en <= 1'b1;
        end else begin
            cpu_clk_en <= cpu_on;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer_clk_en <= 1'b1;
        end else begin
            timer_clk_en <= timer_on;
        end
    end

    // watchdog shares the timer gate, so it can still bite in wait
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_clk_en <= 1'b1;
        end else begin
            watchdog_clk_en <= timer_on;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            side_fx <= '0;
        end else begin
            side_fx <= fx_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chip_reset_req <= 1'b0;
        end else begin
            chip_reset_req <= go_reset && in_run;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode <= 3'h0;
        end else begin
            mode <= state_d;
        end
    end

    AST_STOP_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == low_power_pkg::ST_RUN && go_stop |=> !osc_en && !watchdog_clk_en)
        else $error("stop did not halt oscillator");
    AST_STOP_RESET: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == low_power_pkg::ST_RUN && go_reset |=> chip_reset_req && cpu_clk_en)
        else $error("disabled stop did not reset");
    AST_STOP_FX: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == low_power_pkg::ST_RUN && go_stop |=> side_fx == 5'h1F ##1 side_fx == 5'h00)
        else $error("stop side effects wrong");
    AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == low_power_pkg::ST_STOP && !stop_wake |=> state_q == low_power_pkg::ST_STOP)
        else $error("stop left without wake");
    AST_STAB_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == low_power_pkg::ST_STAB && cnt_q == '0 |-> !cpu_clk_en throughout
        (state_q == low_power_pkg::ST_STAB)[*8])
        else $error("cpu clock resumed early");
    AST_STAB_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == low_power_pkg::ST_STAB && cnt_q == stab_last |=> cpu_clk_en && osc_en)
        else $error("stabilization end wrong");
    AST_WAIT_CLOCKS: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == low_power_pkg::ST_RUN && go_wait |=> !cpu_clk_en && timer_clk_en
        && side_fx.clr_i_bit && !side_fx.set_external_irq_enable)
        else $error("wait entry wrong");
    AST_WAIT_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_q == low_power_pkg::ST_WAIT && wake_in.timer_irq |=> cpu_clk_en)
        else $error("wait wake delayed");
    AST_STOP_CLOCKS_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_stop |-> !osc_en && !cpu_clk_en && !timer_clk_en && !watchdog_clk_en)
        else $error("clock running in stop");
    AST_STOP_EXTERNAL_IRQ_ENABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_run && go_stop |=> side_fx.set_external_irq_enable && side_fx.clr_i_bit)
        else $error("stop entry left irq mask");
    AST_STOP_PRESCALER: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_run && go_stop |=> side_fx.clr_prescaler)
        else $error("prescaler not cleared on stop");
    AST_STOP_TIMER_FX: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_run && go_stop |=> side_fx.clr_timer_ie && side_fx.clr_timer_pend)
        else $error("timer irq not cleared on stop");
    AST_STOP_WINS: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_run && stop_exec && wait_exec && stop_option_en |=> in_stop)
        else $error("wait beat stop");
    AST_RESET_NO_STOP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_run && go_reset |=> in_run)
        else $error("disabled stop entered stop");
    AST_FX_ONLY_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !in_run |=> side_fx == '0)
        else $error("side effect outside entry");
    AST_IRQ_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_stop && wake_in.irq_pin |=> in_stab && cnt_q == '0)
        else $error("irq did not wake stop");
    AST_PORT_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_stop && port_fall |=> in_stab)
        else $error("port edge did not wake stop");
    AST_BUS_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_stop && bus_rise |=> in_stab)
        else $error("bus edge did not wake stop");
    AST_STAB_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_stab && cnt_q != stab_last |=> in_stab && cnt_q == $past(cnt_q) + 1'b1)
        else $error("settle counter skipped");
    AST_STAB_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_stab |-> cnt_q <= stab_last)
        else $error("settle counter overran");
    AST_STAB_GATES: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_stab |-> !cpu_clk_en && osc_en)
        else $error("gates wrong while settling");
    AST_WAIT_TIMERS: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_wait |-> !cpu_clk_en && timer_clk_en && watchdog_clk_en && osc_en)
        else $error("gates wrong in wait");
    AST_WAIT_FX: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_run && go_wait |=> side_fx == 5'h10)
        else $error("wait touched more than the mask");
    AST_WAIT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_wait && !wait_wake |=> in_wait)
        else $error("wait left without wake");
    AST_WAIT_ANY_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_wait && wait_wake |=> in_run && cpu_clk_en)
        else $error("wait wake missed");
    AST_WAIT_INT_RESET: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_wait && int_reset |=> in_run)
        else $error("internal reset did not wake wait");
    AST_RUN_CLOCKS: assert property (@(posedge clk_sys) disable iff (!rst_b)
        in_run |-> cpu_clk_en && timer_clk_en && watchdog_clk_en && osc_en)
        else $error("clock gated in run");

    COV_STOP: cover property (@(posedge clk_sys) state_q == low_power_pkg::ST_STOP ##1
        state_q == low_power_pkg::ST_STAB);
    COV_WAIT: cover property (@(posedge clk_sys) state_q == low_power_pkg::ST_WAIT ##1
        state_q == low_power_pkg::ST_RUN);
    COV_RESET: cover property (@(posedge clk_sys) chip_reset_req);
    COV_PORT_WAKE: cover property (@(posedge clk_sys) in_wait && port_fall);
    COV_BUS_WAKE: cover property (@(posedge clk_sys) in_wait && bus_rise);
endmodule : low_power_mode_control

// [testbench/cpu_core_model.sv]
// cpu side: issues one-cycle stop or wait strobes
module cpu_core_model (
    // clock
    input  wire logic clk_sys,
    // instruction strobes
    output logic      stop_exec,
    output logic      wait_exec
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        stop_exec = 1'b0;
        wait_exec = 1'b0;
    end
    // launched and dropped on rising edges so the block sees exactly one cycle
    task automatic issue(input logic is_stop);
        @(posedge clk_sys);
        stop_exec <= is_stop;
        wait_exec <= ~is_stop;
        @(posedge clk_sys);
        stop_exec <= 1'b0;
        wait_exec <= 1'b0;
    endtask : issue
endmodule : cpu_core_model

// [testbench/low_power_mode_control_bench.sv]
module low_power_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // short stabilization count keeps the run brief
    localparam int STAB = 12;
    logic                    clk_sys   = 1'b0;
    logic                    rst_b     = 1'b0;
    logic                    opt_en    = 1'b1;
    logic                    int_reset = 1'b0;
    low_power_pkg::wake_in_s wake_in   = '0;
    logic [7:0]              pa        = 8'hFF;
    logic [7:0]              pc        = 8'hFF;
    logic [7:0]              da        = 8'h00;
    logic [7:0]              dc        = 8'h00;
    logic                    stop_exec;
    logic                    wait_exec;
    logic [3:0]              clk_ens;
    logic                    rst_req;
    low_power_pkg::side_fx_s side_fx;
    logic [2:0]              mode;
    logic [15:0]             seed      = 16'h6B9C;
    int                      error_cnt   = 0;
    int                      checks_done = 0;
    always #2 clk_sys = ~clk_sys;
    cpu_core_model cpu_core_model_i (.clk_sys(clk_sys), .stop_exec(stop_exec), .wait_exec(wait_exec));
    low_power_mode_control #(.STAB_CYCLES(STAB)) low_power_mode_control_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .stop_exec(stop_exec), .wait_exec(wait_exec),
        .stop_option_en(opt_en), .wake_in(wake_in), .int_reset(int_reset),
        .port_a_pins(pa), .port_c_pins(pc), .port_a_direction_reg(da), .port_c_direction_reg(dc),
        .osc_en(clk_ens[3]), .cpu_clk_en(clk_ens[2]), .timer_clk_en(clk_ens[1]),
        .watchdog_clk_en(clk_ens[0]), .side_fx(side_fx), .chip_reset_req(rst_req), .mode(mode));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // outputs are read 1 ns past the edge, once its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic wait_run(input int lim, output int n);
        n = 0;
        while (mode !== 3'h0 && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_run
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    initial begin
        repeat (2000) @(posedge clk_sys);
        error_cnt++;
        final_report();
    end
    initial begin
        int n;
        logic [2:0] k;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        cpu_core_model_i.issue(1'b1);
        tick(0);
        chk("stop mode", mode, 8'h1);
        chk("stop clocks", clk_ens, 8'h0);
        chk("stop side effects", side_fx, 8'h1F);
        @(posedge clk_sys) wake_in.timer_irq <= 1'b1;
        tick(4);
        chk("no stray effects", side_fx, 8'h0);
        chk("timer cannot wake stop", mode, 8'h1);
        @(posedge clk_sys) wake_in <= 3'b100;
        tick(1);
        chk("stop to stab", mode, 8'h2);
        chk("osc restarts", clk_ens[3], 1'b1);
        @(posedge clk_sys) wake_in <= '0;
        wait_run(1000, n);
        // the cycle spent lowering the wake already counts toward the settle time
        chk("stab length", n[7:0], 8'(STAB - 1));
        chk("cpu clock back", clk_ens[2], 1'b1);
        @(posedge clk_sys) opt_en <= 1'b0;
        cpu_core_model_i.issue(1'b1);
        tick(0);
        chk("reset instead of stop", {rst_req, mode}, 8'h8);
        @(posedge clk_sys) opt_en <= 1'b1;
        cpu_core_model_i.issue(1'b1);
        @(posedge clk_sys) int_reset <= 1'b1;
        tick(1);
        chk("internal reset wakes stop", mode, 8'h2);
        @(posedge clk_sys) int_reset <= 1'b0;
        wait_run(1000, n);
        // one pass per wake source: irq, timer, bus, port, internal reset
        for (int s = 0; s < 5; s++) begin
            seed = lfsr(seed);
            k = seed[2:0];
            cpu_core_model_i.issue(1'b0);
            tick(0);
            chk("wait mode", mode, 8'h3);
            chk("wait clocks", clk_ens, 8'hB);
            chk("wait side effects", side_fx, 8'h10);
            if (s == 3) begin
                @(posedge clk_sys) begin
                    da <= 8'hFF;
                    dc <= 8'hFF;
                end
                @(posedge clk_sys) pa[k] <= 1'b0;
                tick(4);
                chk("output pin masked", mode, 8'h3);
                @(posedge clk_sys) pa[k] <= 1'b1;
                @(posedge clk_sys) begin
                    da <= 8'h00;
                    dc <= 8'h00;
                end
            end
            @(posedge clk_sys)
            case (s)
                0: wake_in.irq_pin <= 1'b1;
                1: wake_in.timer_irq <= 1'b1;
                2: wake_in.bus_pin <= 1'b1;
                3: if (seed[3]) pa[k] <= 1'b0; else pc[k] <= 1'b0;
                default: int_reset <= 1'b1;
            endcase
            tick(1);
            wait_run(3, n);
            chk("wait wake", {clk_ens[2], mode}, 8'h8);
            @(posedge clk_sys) begin
                wake_in <= '0;
                int_reset <= 1'b0;
                pa <= 8'hFF;
                pc <= 8'hFF;
            end
            tick(2);
        end
        final_report();
    end
endmodule : low_power_mode_control_bench
